// *** shared/rtc_pkg.sv ***
/*
 Shared constants for the four-channel retimer control and status block:
 register offsets, field positions, reset values, timing counts and the
 management bus state type. Assumes a 100 MHz system clock.
*/
package rtc_pkg;
	// Channel count and feedback tap count.
	localparam int NUM_CHAN = 4;
	localparam int NUM_TAPS = 5;
	// Per-channel register offsets.
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_EVENT = 8'h02;
	localparam logic [7:0] REG_CHAN_CFG = 8'h03;
	localparam logic [7:0] REG_HWIDTH_THR = 8'h04;
	localparam logic [7:0] REG_VHEIGHT_THR = 8'h05;
	localparam logic [7:0] REG_HWIDTH_SNAP = 8'h06;
	localparam logic [7:0] REG_VHEIGHT_SNAP = 8'h07;
	localparam logic [7:0] REG_CDR_OVR = 8'h09;
	localparam logic [7:0] REG_TAP0 = 8'h10;
	localparam logic [7:0] REG_DATAPATH = 8'h1E;
	localparam logic [7:0] REG_FALSE_LOCK = 8'h2F;
	localparam logic [7:0] REG_ADAPT = 8'h31;
	localparam logic [7:0] REG_CLK_SRC = 8'h36;
	// Global register that picks the channel the per-channel offsets reach.
	localparam logic [7:0] REG_CHAN_SEL = 8'hFF;
	// Field positions.
	localparam int DP_FBEQ_OFF_BIT = 3;
	localparam int DP_MUX_LSB = 5;
	localparam int CDR_BYPASS_BIT = 5;
	localparam int FL_DISABLE_BIT = 1;
	localparam int ADAPT_LSB = 5;
	localparam int CLK_SRC_LSB = 4;
	localparam int CFG_EYE_EN_BIT = 0;
	localparam int CFG_FORCE_OFF_BIT = 1;
	localparam int CFG_MANUAL_TAP_BIT = 2;
	// Values after reset.
	localparam logic [7:0] RST_CDR_OVR = 8'h00;
	localparam logic [7:0] RST_DATAPATH = 8'h08;
	localparam logic [7:0] RST_FALSE_LOCK = 8'h02;
	localparam logic [7:0] RST_ADAPT = 8'h20;
	localparam logic [7:0] RST_CLK_SRC = 8'h30;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Reference clock modes.
	localparam logic [1:0] REF_MODE_NONE = 2'h0;
	localparam logic [1:0] REF_MODE_EXT = 2'h3;
	// Upper bits of the seven-bit bus address; value is arbitrary.
	localparam logic [2:0] SMB_ADDR_HI = 3'h1;
	// Strap settle time after reset release, and its cycle count.
	localparam int CLK_PERIOD_NS = 10;
	localparam int STRAP_SETTLE_NS = 100;
	localparam int STRAP_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Management bus slave states.
	typedef enum logic [3:0] {
		SMB_IDLE, SMB_ADDR, SMB_ADDR_ACK, SMB_REG, SMB_REG_ACK,
		SMB_WDATA, SMB_WDATA_ACK, SMB_RDATA, SMB_RACK, SMB_RNEXT
	} rtc_smb_state_type;
endpackage

// *** shared/rtc_chan_if.sv ***
/*
 Register access carrier between the bus front end and one channel.
 Assumes the front end owns the strobes and the channel owns read data.
*/
`timescale 1ns/1ps
`default_nettype none
interface rtc_chan_if;
	logic wr; // One-cycle write strobe.
	logic rd; // One-cycle read strobe, marks a byte handed to the bus.
	logic [7:0] addr; // Register offset.
	logic [7:0] wdata; // Write data.
	logic [7:0] rdata; // Read data for addr.
	logic pending; // Any latched event not yet cleared.
	modport ctrl (output wr, output rd, output addr, output wdata, input rdata,
		input pending);
	modport chan (input wr, input rd, input addr, input wdata, output rdata,
		output pending);
endinterface
`default_nettype wire

// *** core/rtc_channel.sv ***
/*
 One channel's settings, status synchronisers and event latches.
 Assumes analog status inputs are asynchronous and eye words quasi-static.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_channel
	import rtc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	rtc_chan_if.chan bus,
	input wire logic i_sig_det,
	input wire logic i_cdr_lock,
	input wire logic [7:0] i_eye_width,
	input wire logic [7:0] i_eye_height,
	input wire logic [39:0] i_auto_taps,
	output logic o_fbeq_off,
	output logic o_ctle_adapt,
	output logic o_dfe_adapt,
	output logic [1:0] o_ref_mode,
	output logic o_cdr_bypass,
	output logic [2:0] o_data_mux,
	output logic o_flock_en,
	output logic o_path_on,
	output logic o_coarse_cal,
	output logic o_lock,
	output logic [39:0] o_taps
);
	// Two-stage synchronisers; the eye words are assumed stable across samples.
	logic [17:0] sync1_q, sync2_q;
	// Settings registers.
	logic [7:0] cdr_q, cdr_d, dp_q, dp_d, fl_q, fl_d, ad_q, ad_d, cs_q, cs_d;
	logic [7:0] cfg_q, cfg_d, hthr_q, hthr_d, vthr_q, vthr_d;
	logic [7:0] hsnap_q, hsnap_d, vsnap_q, vsnap_d, ev_q, ev_d;
	logic [7:0] tap_q [NUM_TAPS];
	logic [7:0] tap_d [NUM_TAPS];
	// History for the event edge detectors: falls of sd and lk, rise of below.
	logic sd_prev_q, lk_prev_q, below_prev_q;
	logic sd, lk, below, los, lol, eye;
	logic [39:0] taps_eff;
	logic [7:0] rd_mux;

	// Synchroniser chain; the first stage feeds only the second.
	always_ff @(posedge i_clk)
	begin
		sync1_q <= {i_sig_det, i_cdr_lock, i_eye_width, i_eye_height};
		sync2_q <= sync1_q;
	end

	// Next values of settings, event latches and derived outputs.
	always_comb
	begin
		sd = sync2_q[17];
		lk = sync2_q[16];
		below = (sync2_q[15:8] < hthr_q) || (sync2_q[7:0] < vthr_q);
		los = sd_prev_q && !sd;
		lol = lk_prev_q && !lk;
		eye = cfg_q[CFG_EYE_EN_BIT] && below && !below_prev_q;
		cdr_d = cdr_q;
		dp_d = dp_q;
		fl_d = fl_q;
		ad_d = ad_q;
		cs_d = cs_q;
		cfg_d = cfg_q;
		hthr_d = hthr_q;
		vthr_d = vthr_q;
		for (int t = 0; t < NUM_TAPS; t++)
		begin
			tap_d[t] = tap_q[t];
		end
		if (bus.wr)
		begin
			if (bus.addr == REG_CDR_OVR)
				cdr_d = bus.wdata;
			else if (bus.addr == REG_DATAPATH)
				dp_d = bus.wdata;
			else if (bus.addr == REG_FALSE_LOCK)
				fl_d = bus.wdata;
			else if (bus.addr == REG_ADAPT)
				ad_d = bus.wdata;
			else if (bus.addr == REG_CLK_SRC)
				cs_d = bus.wdata;
			else if (bus.addr == REG_CHAN_CFG)
				cfg_d = bus.wdata;
			else if (bus.addr == REG_HWIDTH_THR)
				hthr_d = bus.wdata;
			else if (bus.addr == REG_VHEIGHT_THR)
				vthr_d = bus.wdata;
			else if (bus.addr >= REG_TAP0 && bus.addr < REG_TAP0 + 8'(NUM_TAPS))
				tap_d[3'(bus.addr - REG_TAP0)] = bus.wdata;
		end
		// latch cause; a new event wins over read-clear
		ev_d = ((bus.rd && bus.addr == REG_EVENT) ? RST_ZERO : ev_q)
			| {5'h00, eye, lol, los};
		hsnap_d = eye ? sync2_q[15:8] : hsnap_q;
		vsnap_d = eye ? sync2_q[7:0] : vsnap_q;
		// manual taps replace adapted ones when chosen
		for (int t = 0; t < NUM_TAPS; t++)
		begin
			taps_eff[t*8 +: 8] = cfg_q[CFG_MANUAL_TAP_BIT] ? tap_q[t] : i_auto_taps[t*8 +: 8];
		end
	end

	// Read data mux; unmapped offsets read as zero.
	always_comb
	begin
		rd_mux = RST_ZERO;
		if (bus.addr == REG_STATUS)
			rd_mux = {5'h00, below, lk, sd};
		else if (bus.addr == REG_EVENT)
			rd_mux = ev_q;
		else if (bus.addr == REG_CHAN_CFG)
			rd_mux = cfg_q;
		else if (bus.addr == REG_HWIDTH_THR)
			rd_mux = hthr_q;
		else if (bus.addr == REG_VHEIGHT_THR)
			rd_mux = vthr_q;
		else if (bus.addr == REG_HWIDTH_SNAP)
			rd_mux = hsnap_q;
		else if (bus.addr == REG_VHEIGHT_SNAP)
			rd_mux = vsnap_q;
		else if (bus.addr == REG_CDR_OVR)
			rd_mux = cdr_q;
		else if (bus.addr == REG_DATAPATH)
			rd_mux = dp_q;
		else if (bus.addr == REG_FALSE_LOCK)
			rd_mux = fl_q;
		else if (bus.addr == REG_ADAPT)
			rd_mux = ad_q;
		else if (bus.addr == REG_CLK_SRC)
			rd_mux = cs_q;
		else if (bus.addr >= REG_TAP0 && bus.addr < REG_TAP0 + 8'(NUM_TAPS))
			rd_mux = taps_eff[6'(bus.addr - REG_TAP0) * 6'd8 +: 8];
	end
	assign bus.rdata = rd_mux;

	// Register stage for all state except the synchronisers, and every output except bus.rdata.
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			cdr_q <= RST_CDR_OVR;
			dp_q <= RST_DATAPATH;
			fl_q <= RST_FALSE_LOCK;
			ad_q <= RST_ADAPT;
			cs_q <= RST_CLK_SRC;
			cfg_q <= RST_ZERO;
			hthr_q <= RST_ZERO;
			vthr_q <= RST_ZERO;
			hsnap_q <= RST_ZERO;
			vsnap_q <= RST_ZERO;
			ev_q <= RST_ZERO;
			for (int t = 0; t < NUM_TAPS; t++)
			begin
				tap_q[t] <= RST_ZERO;
			end
			sd_prev_q <= 1'b0;
			lk_prev_q <= 1'b0;
			below_prev_q <= 1'b0;
			bus.pending <= 1'b0;
			o_fbeq_off <= 1'b1;
			o_ctle_adapt <= 1'b0;
			o_dfe_adapt <= 1'b0;
			o_ref_mode <= REF_MODE_EXT;
			o_cdr_bypass <= 1'b0;
			o_data_mux <= 3'h0;
			o_flock_en <= 1'b0;
			o_path_on <= 1'b0;
			o_coarse_cal <= 1'b0;
			o_lock <= 1'b0;
			o_taps <= 40'h0000000000;
		end
		else
		begin
			cdr_q <= cdr_d;
			dp_q <= dp_d;
			fl_q <= fl_d;
			ad_q <= ad_d;
			cs_q <= cs_d;
			cfg_q <= cfg_d;
			hthr_q <= hthr_d;
			vthr_q <= vthr_d;
			hsnap_q <= hsnap_d;
			vsnap_q <= vsnap_d;
			ev_q <= ev_d;
			tap_q <= tap_d;
			sd_prev_q <= sd;
			lk_prev_q <= lk;
			below_prev_q <= below;
			bus.pending <= |ev_d;
			o_fbeq_off <= dp_q[DP_FBEQ_OFF_BIT];
			o_ctle_adapt <= ad_q[ADAPT_LSB +: 2] != 2'h0;
			o_dfe_adapt <= ad_q[ADAPT_LSB + 1] && !dp_q[DP_FBEQ_OFF_BIT];
			o_ref_mode <= cs_q[CLK_SRC_LSB +: 2];
			o_cdr_bypass <= cdr_q[CDR_BYPASS_BIT];
			o_data_mux <= dp_q[DP_MUX_LSB +: 3];
			o_flock_en <= !fl_q[FL_DISABLE_BIT];
			o_path_on <= sd && !cfg_q[CFG_FORCE_OFF_BIT];
			o_coarse_cal <= (cs_q[CLK_SRC_LSB +: 2] == REF_MODE_EXT) && !lk;
			o_lock <= lk;
			o_taps <= taps_eff;
		end
	end
endmodule
`default_nettype wire

// *** core/rtc_top.sv ***
/*
 Top of the retimer control and status block: management bus slave,
 strap capture on the shared lock pins, reference clock repeat, shared
 interrupt, and four channel instances. Assumes all pins are asynchronous
 to i_clk and that open-drain wires are resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Feedback equalizer powered down until bit cleared
// - Adapt codes 10 or 11 adapt both while feedback equalizer powered
// - Taps adapt automatically or set manually
// - Clock source 00 runs without reference
// - Clock source resets to external reference
// - Reference only calibrates coarse oscillator tuning
// - False-lock detector disabled until bit cleared
// - Reference input repeated on output pin
// - Loss of signal always interrupts
// - Loss of lock always interrupts
// - Eye threshold interrupt, enabled per channel
// - Event cause latched in readable registers
// - Interrupt output open drain, active low
// - Lock pins are address straps first
// - Lock pin high while channel locked
// - Signal detect powers datapath, forced off
module rtc_top
	import rtc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_smb_clk_in,
	input wire logic i_smb_data_in,
	output logic o_smb_data_out,
	output logic o_smb_data_oe,
	input wire logic i_ref_clock_input,
	output logic o_ref_clock_repeat_out,
	output logic o_int_n_out,
	output logic o_int_n_oe,
	input wire logic [3:0] i_lock_pin_in,
	output logic [3:0] o_lock_pin_out,
	output logic [3:0] o_lock_pin_oe,
	output logic [6:0] o_smb_address,
	input wire logic [3:0] i_sig_detect,
	input wire logic [3:0] i_cdr_lock,
	input wire logic [31:0] i_horizontal_eye_width,
	input wire logic [31:0] i_vertical_eye_height,
	input wire logic [159:0] i_auto_tap_weights,
	output logic [3:0] o_feedback_eq_power_down,
	output logic [3:0] o_ctle_adapt_en,
	output logic [3:0] o_dfe_adapt_en,
	output logic [7:0] o_ref_mode,
	output logic [3:0] o_cdr_bypass,
	output logic [11:0] o_data_mux_sel,
	output logic [3:0] o_false_lock_det_en,
	output logic [3:0] o_datapath_power_on,
	output logic [3:0] o_coarse_cal_en,
	output logic [159:0] o_dfe_taps
);
	// Pin synchronisers: scl at bit 1, sda at bit 0.
	logic [1:0] smb_s1_q, smb_s2_q, smb_prev_q;
	logic ref_s1_q, ref_s2_q;
	logic [3:0] strap_s1_q, strap_s2_q;
	// Strap capture.
	logic [3:0] strap_cnt_q, strap_cnt_d, addr_q, addr_d;
	logic strap_done_q, strap_done_d;
	// Bus slave state.
	rtc_smb_state_type st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] shift_q, shift_d, ptr_q, ptr_d, wdata_q, wdata_d;
	logic rw_q, rw_d, oe_q, oe_d, wr_q, wr_d, rd_d;
	logic [1:0] chsel_q, chsel_d;
	// Per-channel read data, pending flags and lock levels.
	logic [7:0] ch_rdata [NUM_CHAN];
	logic [NUM_CHAN-1:0] ch_pending, ch_lock;
	logic scl, sda, scl_rise, scl_fall, start, stop;
	logic [7:0] rdata;

	rtc_chan_if ch_bus [NUM_CHAN] ();

	for (genvar i = 0; i < NUM_CHAN; i++)
	begin : g_chan
		assign ch_bus[i].wr = wr_q && (ptr_q != REG_CHAN_SEL) && (chsel_q == 2'(i));
		// Read clear shares the edge that loads the byte, so no event slips in between.
		assign ch_bus[i].rd = rd_d && (ptr_q != REG_CHAN_SEL) && (chsel_q == 2'(i));
		assign ch_bus[i].addr = ptr_q;
		assign ch_bus[i].wdata = wdata_q;
		assign ch_rdata[i] = ch_bus[i].rdata;
		assign ch_pending[i] = ch_bus[i].pending;
		rtc_channel u_chan (
			.i_clk(i_clk),
			.i_reset(i_reset),
			.bus(ch_bus[i]),
			.i_sig_det(i_sig_detect[i]),
			.i_cdr_lock(i_cdr_lock[i]),
			.i_eye_width(i_horizontal_eye_width[i*8 +: 8]),
			.i_eye_height(i_vertical_eye_height[i*8 +: 8]),
			.i_auto_taps(i_auto_tap_weights[i*40 +: 40]),
			.o_fbeq_off(o_feedback_eq_power_down[i]),
			.o_ctle_adapt(o_ctle_adapt_en[i]),
			.o_dfe_adapt(o_dfe_adapt_en[i]),
			.o_ref_mode(o_ref_mode[i*2 +: 2]),
			.o_cdr_bypass(o_cdr_bypass[i]),
			.o_data_mux(o_data_mux_sel[i*3 +: 3]),
			.o_flock_en(o_false_lock_det_en[i]),
			.o_path_on(o_datapath_power_on[i]),
			.o_coarse_cal(o_coarse_cal_en[i]),
			.o_lock(ch_lock[i]),
			.o_taps(o_dfe_taps[i*40 +: 40])
		);
	end

	// Synchronisers; first stages are read only by second stages.
	always_ff @(posedge i_clk)
	begin
		smb_s1_q <= {i_smb_clk_in, i_smb_data_in};
		smb_s2_q <= smb_s1_q;
		smb_prev_q <= smb_s2_q;
		ref_s1_q <= i_ref_clock_input;
		ref_s2_q <= ref_s1_q;
		strap_s1_q <= i_lock_pin_in;
		strap_s2_q <= strap_s1_q;
	end

	// Read data seen by the bus: channel select or the selected channel.
	always_comb
	begin
		if (ptr_q == REG_CHAN_SEL)
			rdata = {6'h00, chsel_q};
		else
			rdata = ch_rdata[chsel_q];
	end

	// Next state of the strap capture and the bus slave.
	always_comb
	begin
		scl = smb_s2_q[1];
		sda = smb_s2_q[0];
		scl_rise = scl && !smb_prev_q[1];
		scl_fall = !scl && smb_prev_q[1];
		// Data moving while the clock is high frames a transfer.
		start = scl && smb_prev_q[1] && smb_prev_q[0] && !sda;
		stop = scl && smb_prev_q[1] && !smb_prev_q[0] && sda;
		strap_cnt_d = strap_cnt_q;
		strap_done_d = strap_done_q;
		addr_d = addr_q;
		// sample straps once they have settled
		if (!strap_done_q)
		begin
			if (strap_cnt_q == 4'(STRAP_CYCLES - 1))
			begin
				addr_d = strap_s2_q;
				strap_done_d = 1'b1;
			end
			else
				strap_cnt_d = strap_cnt_q + 4'h1;
		end
		st_d = st_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		wdata_d = wdata_q;
		rw_d = rw_q;
		oe_d = oe_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		chsel_d = (wr_q && ptr_q == REG_CHAN_SEL) ? wdata_q[1:0] : chsel_q;
		// The bus stays deaf until the address is known.
		if (start && strap_done_q)
		begin
			st_d = SMB_ADDR;
			cnt_d = 3'h0;
			oe_d = 1'b0;
		end
		else if (stop)
		begin
			st_d = SMB_IDLE;
			oe_d = 1'b0;
		end
		else
		begin
			case (st_q)
				SMB_ADDR, SMB_REG, SMB_WDATA:
				begin
					// Bits are sampled on the clock's rising edge, MSB first.
					if (scl_rise)
					begin
						shift_d = {shift_q[6:0], sda};
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == 3'h7)
						begin
							if (st_q == SMB_ADDR)
								st_d = SMB_ADDR_ACK;
							else if (st_q == SMB_REG)
								st_d = SMB_REG_ACK;
							else
								st_d = SMB_WDATA_ACK;
						end
					end
				end
				SMB_ADDR_ACK:
				begin
					if (scl_fall && !oe_q)
					begin
						// Foreign addresses are simply ignored until the next start.
						if (shift_q[7:1] == {SMB_ADDR_HI, addr_q})
						begin
							oe_d = 1'b1;
							rw_d = shift_q[0];
						end
						else
							st_d = SMB_IDLE;
					end
					else if (scl_fall)
					begin
						if (rw_q)
						begin
							shift_d = rdata;
							rd_d = 1'b1;
							oe_d = !rdata[7];
							cnt_d = 3'h0;
							st_d = SMB_RDATA;
						end
						else
						begin
							oe_d = 1'b0;
							st_d = SMB_REG;
						end
					end
				end
				SMB_REG_ACK:
				begin
					if (scl_fall && !oe_q)
					begin
						ptr_d = shift_q;
						oe_d = 1'b1;
					end
					else if (scl_fall)
					begin
						oe_d = 1'b0;
						st_d = SMB_WDATA;
					end
				end
				SMB_WDATA_ACK:
				begin
					// The write lands while ptr still names the target offset.
					if (scl_fall && !oe_q)
					begin
						wdata_d = shift_q;
						wr_d = 1'b1;
						oe_d = 1'b1;
					end
					else if (scl_fall)
					begin
						oe_d = 1'b0;
						ptr_d = ptr_q + 8'h01;
						st_d = SMB_WDATA;
					end
				end
				SMB_RDATA:
				begin
					// Data changes only while the clock is low.
					if (scl_fall && cnt_q == 3'h7)
					begin
						oe_d = 1'b0;
						st_d = SMB_RACK;
					end
					else if (scl_fall)
					begin
						cnt_d = cnt_q + 3'h1;
						shift_d = {shift_q[6:0], 1'b0};
						oe_d = !shift_q[6];
					end
				end
				SMB_RACK:
				begin
					// A master acknowledge asks for the next byte.
					if (scl_rise && !sda)
					begin
						ptr_d = ptr_q + 8'h01;
						st_d = SMB_RNEXT;
					end
					else if (scl_rise)
						st_d = SMB_IDLE;
				end
				SMB_RNEXT:
				begin
					if (scl_fall)
					begin
						shift_d = rdata;
						rd_d = 1'b1;
						oe_d = !rdata[7];
						cnt_d = 3'h0;
						st_d = SMB_RDATA;
					end
				end
				default:
				begin
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// Register stage for the bus slave, straps and pin outputs.
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			strap_cnt_q <= 4'h0;
			strap_done_q <= 1'b0;
			addr_q <= 4'h0;
			st_q <= SMB_IDLE;
			cnt_q <= 3'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			wdata_q <= 8'h00;
			rw_q <= 1'b0;
			oe_q <= 1'b0;
			wr_q <= 1'b0;
			chsel_q <= 2'h0;
			o_smb_data_out <= 1'b0;
			o_smb_data_oe <= 1'b0;
			o_ref_clock_repeat_out <= 1'b0;
			o_int_n_out <= 1'b0;
			o_int_n_oe <= 1'b0;
			o_lock_pin_out <= 4'h0;
			o_lock_pin_oe <= 4'h0;
			o_smb_address <= 7'h00;
		end
		else
		begin
			strap_cnt_q <= strap_cnt_d;
			strap_done_q <= strap_done_d;
			addr_q <= addr_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			wdata_q <= wdata_d;
			rw_q <= rw_d;
			oe_q <= oe_d;
			wr_q <= wr_d;
			chsel_q <= chsel_d;
			o_smb_data_out <= 1'b0;
			o_smb_data_oe <= oe_d;
			o_ref_clock_repeat_out <= ref_s2_q;
			// open drain: only ever pulls low
			o_int_n_out <= 1'b0;
			// pull low while any event pending
			o_int_n_oe <= |ch_pending;
			o_lock_pin_out <= ch_lock;
			// drive only after straps are latched
			o_lock_pin_oe <= {4{strap_done_q}};
			o_smb_address <= {SMB_ADDR_HI, addr_q};
		end
	end
endmodule
`default_nettype wire

// *** sim/rtc_mgmt_model.sv ***
/*
 Management controller model: an open-drain bus master that writes and
 reads registers and keeps a sticky flag of missing acknowledges.
 Assumes the bench resolves the data wire with its pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_mgmt_model
(
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	logic [6:0] dev; // Address of the device being called.
	logic nak; // Set when any byte went unacknowledged.
	int q_len; // Clocks per quarter bit; the bench varies it.
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		dev = 7'h00;
		nak = 1'b0;
		q_len = 3;
	end
	task qw;
		repeat (q_len) @(posedge i_clk);
	endtask
	// One bit: data set while the clock is low, sampled in the middle of the high half.
	task bitx(input logic b, output logic s);
		o_sda <= b;
		qw;
		o_scl <= 1'b1;
		qw;
		s = i_sda;
		qw;
		o_scl <= 1'b0;
		qw;
	endtask
	task byte_x(input logic [7:0] b, output logic [7:0] r);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(b[i], s);
			r[i] = s;
		end
	endtask
	// Start or repeated start: data falls while the clock is high.
	task start;
		o_sda <= 1'b1;
		qw;
		o_scl <= 1'b1;
		qw;
		o_sda <= 1'b0;
		qw;
		o_scl <= 1'b0;
		qw;
	endtask
	task stop;
		o_sda <= 1'b0;
		qw;
		o_scl <= 1'b1;
		qw;
		o_sda <= 1'b1;
		qw;
	endtask
	task send(input logic [7:0] b);
		logic [7:0] r;
		logic a;
		byte_x(b, r);
		bitx(1'b1, a);
		nak = nak | a;
	endtask
	task wr(input logic [7:0] off, input logic [7:0] d);
		start;
		send({dev, 1'b0});
		send(off);
		send(d);
		stop;
	endtask
	task rd(input logic [7:0] off, output logic [7:0] d);
		logic a;
		start;
		send({dev, 1'b0});
		send(off);
		start;
		send({dev, 1'b1});
		byte_x(8'hFF, d);
		bitx(1'b1, a);
		stop;
	endtask
endmodule
`default_nettype wire

// *** sim/rtc_props.sv ***
/*
 Checker for the retimer control top: pins, straps, reset values, events.
 Assumes it is bound to rtc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_props
	import rtc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ref_clock_input,
	input wire logic [3:0] i_sig_detect,
	input wire logic [3:0] i_cdr_lock,
	input wire logic o_ref_clock_repeat_out,
	input wire logic o_int_n_out,
	input wire logic o_int_n_oe,
	input wire logic [3:0] o_lock_pin_out,
	input wire logic [3:0] o_lock_pin_oe,
	input wire logic [6:0] o_smb_address,
	input wire logic [3:0] o_feedback_eq_power_down,
	input wire logic [3:0] o_ctle_adapt_en,
	input wire logic [3:0] o_dfe_adapt_en,
	input wire logic [7:0] o_ref_mode,
	input wire logic [3:0] o_false_lock_det_en,
	input wire logic [3:0] o_datapath_power_on,
	input wire logic [3:0] o_coarse_cal_en
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	logic [3:0] up_q; // Clocks since reset release, saturating.
	logic [3:0] up_d;
	// Channels whose clock source selects the external reference.
	wire logic [3:0] ext_ref = {&o_ref_mode[7:6], &o_ref_mode[5:4], &o_ref_mode[3:2],
		&o_ref_mode[1:0]};
	// Saturating keeps the count small; only the first fifteen clocks matter.
	always_comb
	begin
		up_d = up_q;
		if (i_reset)
			up_d = 4'h0;
		else if (up_q != 4'hF)
			up_d = up_q + 4'h1;
	end
	always_ff @(posedge i_clk)
	begin
		up_q <= up_d;
	end
	// Inputs held long enough for the synchronisers to settle.
	sequence lock_steady;
		$stable(i_cdr_lock) [*8];
	endsequence
	sequence sig_steady;
		$stable(i_sig_detect) [*6];
	endsequence
	sequence sig_lost;
		(up_q == 4'hF) && ((~i_sig_detect & $past(i_sig_detect)) != 4'h0);
	endsequence
	ref_copy_a:
		assert property (up_q >= 4'h4 |-> o_ref_clock_repeat_out == $past(i_ref_clock_input, 3))
		else $error("reference copy differs");
	int_drain_a:
		assert property (o_int_n_out == 1'b0) else $error("interrupt pin driven high");
	strap_first_a:
		assert property (up_q < 4'h8 |-> o_lock_pin_oe == 4'h0) else $error("lock pins early");
	lock_drive_a:
		assert property (up_q == 4'hF |-> o_lock_pin_oe == 4'hF) else $error("lock pins not driven");
	addr_hold_a:
		assert property (o_lock_pin_oe[0] |=> $stable(o_smb_address)
			&& o_smb_address[6:4] == SMB_ADDR_HI) else $error("address not held");
	lock_follow_a:
		assert property (lock_steady ##0 o_lock_pin_oe == 4'hF |-> o_lock_pin_out == i_cdr_lock)
		else $error("lock pin wrong");
	reset_vals_a:
		assert property ($fell(i_reset) |-> o_feedback_eq_power_down == 4'hF
			&& o_ref_mode == 8'hFF && o_false_lock_det_en == 4'h0) else $error("reset settings");
	dfe_adapt_a:
		assert property ((o_dfe_adapt_en & (o_feedback_eq_power_down | ~o_ctle_adapt_en)) == 4'h0)
		else $error("feedback adapt wrong");
	coarse_ref_a:
		assert property (lock_steady |-> (o_coarse_cal_en & ~(ext_ref & ~i_cdr_lock)) == 4'h0)
		else $error("calibration without reference");
	los_int_a:
		assert property (sig_lost |-> ##[1:10] o_int_n_oe) else $error("no interrupt on loss");
	sigdet_power_a:
		assert property (sig_steady |-> (o_datapath_power_on & ~i_sig_detect) == 4'h0)
		else $error("path on without signal");
endmodule
bind rtc_top rtc_props u_props (.*);
`default_nettype wire

// *** sim/test_rtc_top.sv ***
/*
 Self-checking bench for rtc_top: settings, straps, events and interrupt.
 Assumes rtc_mgmt_model acts as the controller and rtc_props is bound.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rtc_top;
	import rtc_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_ref_clock_input = 1'b0;
	logic [3:0] i_sig_detect = 4'h0;
	logic [3:0] i_cdr_lock = 4'h0;
	logic [3:0] strap = 4'h0;
	logic [31:0] i_horizontal_eye_width = 32'hFFFFFFFF;
	logic [31:0] i_vertical_eye_height = 32'hFFFFFFFF;
	logic [159:0] i_auto_tap_weights = 160'h0;
	logic i_smb_clk_in, sda_m, o_smb_data_out, o_smb_data_oe;
	logic o_ref_clock_repeat_out, o_int_n_out, o_int_n_oe;
	logic [3:0] o_lock_pin_out, o_lock_pin_oe, o_feedback_eq_power_down, o_ctle_adapt_en;
	logic [3:0] o_dfe_adapt_en, o_cdr_bypass, o_false_lock_det_en, o_datapath_power_on;
	logic [3:0] o_coarse_cal_en;
	logic [6:0] o_smb_address;
	logic [7:0] o_ref_mode, rv;
	logic [11:0] o_data_mux_sel;
	logic [159:0] o_dfe_taps;
	logic [1:0] ch, rc = 2'h0;
	int failures = 0;
	int comparisons = 0;
	// Pulled-up data wire: low whenever either side pulls it.
	wire logic i_smb_data_in = sda_m & (~o_smb_data_oe | o_smb_data_out);
	// Lock pins show the straps until the device drives them.
	wire logic [3:0] i_lock_pin_in = o_lock_pin_oe & o_lock_pin_out | ~o_lock_pin_oe & strap;
	rtc_top uut (.*);
	rtc_mgmt_model mm (.i_clk(i_clk), .i_sda(i_smb_data_in), .o_scl(i_smb_clk_in), .o_sda(sda_m));
	always #5 i_clk = ~i_clk;
	// Reference at 25 MHz: a four-clock period.
	always @(posedge i_clk)
	begin
		rc <= rc + 2'h1;
		i_ref_clock_input <= rc[1];
	end
	// Expected {feedback adapt, linear adapt} from code k[1:0] and power-down k[2].
	function automatic logic [7:0] adapt_exp(input logic [2:0] k);
		return {6'h0, k[1] & ~k[2], k[1:0] != 2'h0};
	endfunction
	task test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wrc(input logic [7:0] off, input logic [7:0] d);
		mm.q_len = 3 + $urandom % 2;
		mm.wr(8'hFF, {6'h0, ch});
		mm.wr(off, d);
		@(negedge i_clk);
	endtask
	task rdc(input logic [7:0] off);
		mm.wr(8'hFF, {6'h0, ch});
		mm.rd(off, rv);
	endtask
	task wait_int(input logic lvl);
		int n;
		n = 0;
		while (o_int_n_oe !== lvl && n < 40)
		begin
			@(negedge i_clk);
			n++;
		end
		chk("interrupt", {7'h0, lvl}, {7'h0, o_int_n_oe});
		if (o_int_n_oe !== lvl)
			test_done;
	endtask
	initial
	begin
		repeat (100000) @(posedge i_clk);
		failures++;
		test_done;
	end
	initial
	begin
		rv = $urandom(32'hF6F1);
		strap = $urandom;
		ch = $urandom;
		i_auto_tap_weights = {$urandom, $urandom, $urandom, $urandom, $urandom};
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		i_sig_detect <= 4'hF;
		i_cdr_lock <= 4'hF;
		mm.dev = {SMB_ADDR_HI, strap};
		repeat (20) @(posedge i_clk);
		chk("address", {1'b0, SMB_ADDR_HI, strap}, {1'b0, o_smb_address});
		chk("lock pins", 8'hFF, {o_lock_pin_oe, o_lock_pin_out});
		chk("auto tap", i_auto_tap_weights[ch*40+:8], o_dfe_taps[ch*40+:8]);
		for (int i = 0; i < 5; i++)
		begin
			rdc(8'(40'h091E2F3136 >> (8 * i)));
			chk("reset value", 8'(40'h0008022030 >> (8 * i)), rv);
		end
		$display("reset values done");
		for (int k = 0; k < 8; k++)
		begin
			wrc(8'h1E, {4'h0, k[2], 3'h0});
			wrc(8'h31, {1'b0, k[1:0], 5'h00});
			chk("adapt", adapt_exp(k[2:0]), {6'h0, o_dfe_adapt_en[ch], o_ctle_adapt_en[ch]});
		end
		wrc(8'h1E, 8'h00);
		chk("power down", 8'h0F ^ (8'h01 << ch), {4'h0, o_feedback_eq_power_down});
		for (int m = 0; m < 4; m++)
		begin
			wrc(8'h36, 8'(m << 4));
			chk("ref mode", 8'(m), {6'h0, o_ref_mode[ch*2+:2]});
		end
		// Low-rate setup: recovery bypassed and data mux cleared.
		wrc(8'h1E, 8'hE0);
		chk("mux", 8'h07, {5'h0, o_data_mux_sel[ch*3+:3]});
		wrc(8'h09, 8'h20);
		wrc(8'h1E, 8'h00);
		chk("bypass", 8'h01 << ch, {4'h0, o_cdr_bypass});
		chk("mux", 8'h00, {5'h0, o_data_mux_sel[ch*3+:3]});
		wrc(8'h2F, 8'h00);
		chk("false lock", 8'h01 << ch, {4'h0, o_false_lock_det_en});
		wrc(8'h03, 8'h02);
		chk("path on", 8'h0F ^ (8'h01 << ch), {4'h0, o_datapath_power_on});
		wrc(8'h03, 8'h04);
		wrc(8'h10, 8'h5A);
		chk("manual tap", 8'h5A, o_dfe_taps[ch*40+:8]);
		rdc(8'h10);
		chk("tap read", 8'h5A, rv);
		wrc(8'h03, 8'h00);
		rdc(8'h40);
		chk("unmapped", 8'h00, rv);
		chk("ack", 8'h00, {7'h0, mm.nak});
		$display("settings done");
		// Three event kinds: signal lost, lock lost, eye below threshold.
		for (int e = 0; e < 3; e++)
		begin
			ch = $urandom;
			if (e == 2)
			begin
				wrc(8'h04, 8'h80);
				wrc(8'h03, 8'h01);
			end
			chk("int idle", 8'h00, {7'h0, o_int_n_oe});
			@(posedge i_clk);
			if (e == 0)
				i_sig_detect[ch] <= 1'b0;
			else if (e == 1)
				i_cdr_lock[ch] <= 1'b0;
			else
				i_horizontal_eye_width[ch*8+:8] <= 8'h40;
			wait_int(1'b1);
			rdc(8'h02);
			chk("event", 8'h01 << e, rv);
			wait_int(1'b0);
			rdc(8'h02);
			chk("event cleared", 8'h00, rv);
			@(posedge i_clk);
			i_sig_detect <= 4'hF;
			i_cdr_lock <= 4'hF;
			i_horizontal_eye_width <= 32'hFFFFFFFF;
			wrc(8'h03, 8'h00);
		end
		$display("events done");
		mm.dev = mm.dev ^ 7'h01;
		mm.wr(8'hFF, 8'h00);
		chk("no ack", 8'h01, {7'h0, mm.nak});
		$display("address refusal done");
		test_done;
	end
endmodule
`default_nettype wire
